// ### core/compare_output_switch.sv
// Compare unit of one counting channel with a Wishbone register file.
`timescale 1ns/1ps
module compare_output_switch (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Reference values from the counting logic
    input  wire logic [31:0] count_value,
    input  wire logic        count_pulse,
    input  wire logic        count_up,
    input  wire logic [31:0] pos_value,
    input  wire logic        pos_update,
    input  wire logic [31:0] meas_value,
    // Digital outputs and feedback
    output logic             switch_out_zero,
    output logic             switch_out_one,
    output logic      [1:0]  out_state_flag,
    output logic      [1:0]  compare_hit_flag
);

    logic [31:0] ctrl_q;
    logic [31:0] cmp_q [2];
    logic [15:0] pulse_len_q;
    logic [31:0] pos_max_q;
    logic [31:0] low_lim_q;
    logic [31:0] high_lim_q;
    logic [31:0] pos_prev_q;
    logic [1:0]  out_q;
    logic [1:0]  hit_q;
    logic [1:0]  hit_clr;
    logic [31:0] rd_d;
    logic [31:0] pulse_wr;
    logic        bus_req;
    logic        wr_en;

    cmp_pkg::ref_e      ref_sel;
    logic signed [31:0] ref_now;
    logic signed [31:0] ref_prev;
    logic               step;
    logic               moving_up;
    logic               moving_dn;

    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // One-cycle acknowledge; ack drops in the cycle after it is given.
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en   = bus_req && wb_we_i;
    // Only lanes 0 and 1 reach the 16-bit pulse length.
    assign pulse_wr = merge({16'h0000, pulse_len_q}, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= rd_d;
            end
        end
    end

    always_comb
    begin
        case (wb_adr_i)
            cmp_pkg::OFS_CTRL:      rd_d = ctrl_q;
            cmp_pkg::OFS_CMP0:      rd_d = cmp_q[0];
            cmp_pkg::OFS_CMP1:      rd_d = cmp_q[1];
            cmp_pkg::OFS_PULSE_LEN: rd_d = {16'h0000, pulse_len_q};
            cmp_pkg::OFS_STATUS:    rd_d = {28'h0000000, hit_q, out_q};
            cmp_pkg::OFS_POS_MAX:   rd_d = pos_max_q;
            cmp_pkg::OFS_LOW_LIM:   rd_d = low_lim_q;
            cmp_pkg::OFS_HIGH_LIM:  rd_d = high_lim_q;
            default:                rd_d = 32'h0000_0000;
        endcase
    end

    // Configuration; compare values may be rewritten at any time.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q      <= cmp_pkg::RST_CTRL;
            cmp_q[0]    <= cmp_pkg::RST_CMP;
            cmp_q[1]    <= cmp_pkg::RST_CMP;
            pulse_len_q <= cmp_pkg::RST_PULSE_LEN;
            pos_max_q   <= cmp_pkg::RST_POS_MAX;
            low_lim_q   <= cmp_pkg::RST_LOW_LIM;
            high_lim_q  <= cmp_pkg::RST_HIGH_LIM;
        end
        else if (wr_en)
        begin
            case (wb_adr_i)
                cmp_pkg::OFS_CTRL:
                begin
                    ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) &
                              32'h0003_773F;
                end
                cmp_pkg::OFS_CMP0:
                begin
                    cmp_q[0] <= merge(cmp_q[0], wb_dat_i, wb_sel_i);
                end
                cmp_pkg::OFS_CMP1:
                begin
                    cmp_q[1] <= merge(cmp_q[1], wb_dat_i, wb_sel_i);
                end
                cmp_pkg::OFS_PULSE_LEN:
                begin
                    pulse_len_q <= pulse_wr[15:0];
                end
                cmp_pkg::OFS_POS_MAX:
                begin
                    pos_max_q <= merge(pos_max_q, wb_dat_i, wb_sel_i);
                end
                cmp_pkg::OFS_LOW_LIM:
                begin
                    low_lim_q <= merge(low_lim_q, wb_dat_i, wb_sel_i);
                end
                cmp_pkg::OFS_HIGH_LIM:
                begin
                    high_lim_q <= merge(high_lim_q, wb_dat_i, wb_sel_i);
                end
                default:
                begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // Hit flags clear by writing one to the status register.
    assign hit_clr = (wr_en && (wb_adr_i == cmp_pkg::OFS_STATUS) &&
                      wb_sel_i[0]) ?
                     wb_dat_i[cmp_pkg::STAT_HIT_LSB +: 2] : 2'h0;

    // Reference selection and its step of movement.
    always_comb
    begin
        ref_sel = cmp_pkg::ref_e'(ctrl_q[cmp_pkg::CTRL_REF_LSB +: 2]);
        case (ref_sel)
            cmp_pkg::REF_POS:
            begin
                ref_now   = pos_value;
                ref_prev  = pos_prev_q;
                step      = pos_update;
                moving_up = $signed(pos_value) > $signed(pos_prev_q);
                moving_dn = $signed(pos_value) < $signed(pos_prev_q);
            end
            cmp_pkg::REF_MEAS:
            begin
                ref_now   = meas_value;
                ref_prev  = meas_value;
                step      = 1'b0;
                moving_up = 1'b0;
                moving_dn = 1'b0;
            end
            default:
            begin
                // A load changes the value without a pulse.
                ref_now   = count_value;
                ref_prev  = count_value;
                step      = count_pulse;
                moving_up = count_up;
                moving_dn = !count_up;
            end
        endcase
    end

    // Last position sample, for direction and crossing.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pos_prev_q <= 32'h0000_0000;
        end
        else if (pos_update)
        begin
            pos_prev_q <= pos_value;
        end
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_out
        cmp_if lnk ();
        logic own;
        logic set_b;

        assign own   = ctrl_q[cmp_pkg::CTRL_OWN_LSB + i];
        assign set_b = ctrl_q[cmp_pkg::CTRL_SET_LSB + i];

        assign lnk.ref_sel    = ref_sel;
        assign lnk.mode       = cmp_pkg::mode_e'(
                                ctrl_q[cmp_pkg::CTRL_MODE0_LSB + 4*i +: 3]);
        assign lnk.is_out_one = (i == 1);
        assign lnk.dir_up_cfg = ctrl_q[cmp_pkg::CTRL_DIR_LSB + i];
        assign lnk.set_bit    = set_b;
        assign lnk.step       = step;
        assign lnk.moving_up  = moving_up;
        assign lnk.moving_dn  = moving_dn;
        assign lnk.ref_now    = ref_now;
        assign lnk.ref_prev   = ref_prev;
        assign lnk.cmp        = cmp_q[i];
        assign lnk.cmp0       = cmp_q[0];
        assign lnk.cmp1       = cmp_q[1];
        assign lnk.low_lim    = low_lim_q;
        assign lnk.high_lim   = high_lim_q;
        assign lnk.pos_max    = pos_max_q;
        assign lnk.pulse_len  = pulse_len_q;

        cmp_eval u_eval (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .lnk     (lnk.eval)
        );

        // Owner bit picks software or the compare function.
        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                out_q[i] <= 1'b0;
            end
            else
            begin
                out_q[i] <= own ? lnk.fn_level : set_b;
            end
        end

        // A hit arriving with a clear is kept.
        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                hit_q[i] <= 1'b0;
            end
            else if (lnk.match)
            begin
                hit_q[i] <= 1'b1;
            end
            else if (hit_clr[i])
            begin
                hit_q[i] <= 1'b0;
            end
        end
    end

    assign switch_out_zero  = out_q[0];
    assign switch_out_one   = out_q[1];
    assign out_state_flag   = out_q;
    assign compare_hit_flag = hit_q;

endmodule : compare_output_switch

// ### core/cmp_pkg.sv
// Constants, register map and mode codes of the compare output switch.
package cmp_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CMP0      = 8'h04;
    localparam logic [7:0] OFS_CMP1      = 8'h08;
    localparam logic [7:0] OFS_PULSE_LEN = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_POS_MAX   = 8'h14;
    localparam logic [7:0] OFS_LOW_LIM   = 8'h18;
    localparam logic [7:0] OFS_HIGH_LIM  = 8'h1C;

    // Control register field positions.
    localparam int CTRL_OWN_LSB  = 0;
    localparam int CTRL_SET_LSB  = 2;
    localparam int CTRL_REF_LSB  = 4;
    localparam int CTRL_MODE0_LSB = 8;
    localparam int CTRL_MODE1_LSB = 12;
    localparam int CTRL_DIR_LSB  = 16;

    // Status register field positions.
    localparam int STAT_OUT_LSB = 0;
    localparam int STAT_HIT_LSB = 2;

    // Values after reset.
    localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
    localparam logic [31:0] RST_CMP       = 32'h0000_0000;
    localparam logic [15:0] RST_PULSE_LEN = 16'h0000;
    localparam logic [31:0] RST_POS_MAX   = 32'h0000_FFFF;
    localparam logic [31:0] RST_LOW_LIM   = 32'h8000_0000;
    localparam logic [31:0] RST_HIGH_LIM  = 32'h7FFF_FFFF;

    // Comparison events.
    typedef enum logic [2:0] {
        MODE_OFF       = 3'h0,
        MODE_UPPER     = 3'h1,
        MODE_LOWER     = 3'h2,
        MODE_WINDOW    = 3'h3,
        MODE_PULSE     = 3'h4,
        MODE_SET_UNTIL = 3'h5,
        MODE_OUTSIDE   = 3'h6
    } mode_e;

    // Comparison reference.
    typedef enum logic [1:0] {
        REF_COUNT = 2'h0,
        REF_POS   = 2'h1,
        REF_MEAS  = 2'h2
    } ref_e;

endpackage : cmp_pkg

// ### core/cmp_if.sv
// Link between the channel core and one output evaluator.
`timescale 1ns/1ps
interface cmp_if;
    cmp_pkg::ref_e      ref_sel;
    cmp_pkg::mode_e     mode;
    logic               is_out_one;
    logic               dir_up_cfg;
    logic               set_bit;
    logic               step;
    logic               moving_up;
    logic               moving_dn;
    logic signed [31:0] ref_now;
    logic signed [31:0] ref_prev;
    logic signed [31:0] cmp;
    logic signed [31:0] cmp0;
    logic signed [31:0] cmp1;
    logic signed [31:0] low_lim;
    logic signed [31:0] high_lim;
    logic signed [31:0] pos_max;
    logic [15:0]        pulse_len;
    logic               fn_level;
    logic               match;

    modport ctrl (
        output ref_sel, mode, is_out_one, dir_up_cfg, set_bit, step,
        output moving_up, moving_dn, ref_now, ref_prev, cmp, cmp0, cmp1,
        output low_lim, high_lim, pos_max, pulse_len,
        input  fn_level, match
    );
    modport eval (
        input  ref_sel, mode, is_out_one, dir_up_cfg, set_bit, step,
        input  moving_up, moving_dn, ref_now, ref_prev, cmp, cmp0, cmp1,
        input  low_lim, high_lim, pos_max, pulse_len,
        output fn_level, match
    );
endinterface : cmp_if

// ### core/cmp_eval.sv
// Comparison function of one output: ranges, pulse and set-until-match.
`timescale 1ns/1ps
module cmp_eval (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Link to the channel core
    cmp_if.eval       lnk
);

    logic        reach;
    logic        dir_ok;
    logic        hit_raw;
    logic        in_upper;
    logic        in_lower;
    logic        in_win;
    logic        armed_q;
    logic        hold_q;
    logic        latch_q;
    logic        set_prev_q;
    logic        fn_q;
    logic        fn_d;
    logic [15:0] pulse_cnt_q;

    // All comparisons are signed.
    always_comb
    begin
        in_upper = 1'b0;
        in_lower = 1'b0;
        case (lnk.ref_sel)
            cmp_pkg::REF_COUNT:
            begin
                in_upper = (lnk.cmp <= lnk.ref_now) &&
                           (lnk.ref_now <= lnk.high_lim);
                in_lower = (lnk.low_lim <= lnk.ref_now) &&
                           (lnk.ref_now <= lnk.cmp);
            end
            cmp_pkg::REF_POS:
            begin
                in_upper = (lnk.cmp <= lnk.ref_now) &&
                           (lnk.ref_now <= lnk.pos_max);
                in_lower = (lnk.ref_now >= 32'sh0) &&
                           (lnk.ref_now <= lnk.cmp);
            end
            cmp_pkg::REF_MEAS:
            begin
                in_upper = lnk.ref_now >= lnk.cmp;
                in_lower = lnk.ref_now <= lnk.cmp;
            end
            default:
            begin
                in_upper = 1'b0;
                in_lower = 1'b0;
            end
        endcase
    end

    // Inclusive window, shared by all references.
    assign in_win = (lnk.cmp0 <= lnk.ref_now) && (lnk.ref_now <= lnk.cmp1);

    // A slow position sample may jump over the compare value, so a
    // crossing counts as reaching it.
    always_comb
    begin
        if (lnk.ref_sel == cmp_pkg::REF_POS)
        begin
            if (lnk.dir_up_cfg)
            begin
                reach = (lnk.ref_prev < lnk.cmp) && (lnk.ref_now >= lnk.cmp);
            end
            else
            begin
                reach = (lnk.ref_prev > lnk.cmp) && (lnk.ref_now <= lnk.cmp);
            end
        end
        else
        begin
            reach = lnk.ref_now == lnk.cmp;
        end
    end

    assign dir_ok = lnk.dir_up_cfg ? lnk.moving_up : lnk.moving_dn;

    // Only a step of the reference can match, so a load never does.
    assign hit_raw = lnk.step && dir_ok && reach &&
                     (lnk.ref_sel != cmp_pkg::REF_MEAS) &&
                     ((lnk.mode == cmp_pkg::MODE_PULSE) ||
                      (lnk.mode == cmp_pkg::MODE_SET_UNTIL));
    assign lnk.match = hit_raw && armed_q;

    // Rearm once the reference has left the compare value.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            armed_q <= 1'b1;
        end
        else if (hit_raw)
        begin
            armed_q <= 1'b0;
        end
        else if (lnk.ref_now != lnk.cmp)
        begin
            armed_q <= 1'b1;
        end
    end

    // Pulse duration in clock cycles.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pulse_cnt_q <= 16'h0000;
        end
        else if (lnk.mode != cmp_pkg::MODE_PULSE)
        begin
            pulse_cnt_q <= 16'h0000;
        end
        else if (lnk.match)
        begin
            pulse_cnt_q <= lnk.pulse_len;
        end
        else if (pulse_cnt_q != 16'h0000)
        begin
            pulse_cnt_q <= pulse_cnt_q - 16'h0001;
        end
    end

    // Zero duration holds the output until the next step.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_q <= 1'b0;
        end
        else if (lnk.mode != cmp_pkg::MODE_PULSE)
        begin
            hold_q <= 1'b0;
        end
        else if (lnk.match && (lnk.pulse_len == 16'h0000))
        begin
            hold_q <= 1'b1;
        end
        else if (lnk.step)
        begin
            hold_q <= 1'b0;
        end
    end

    // Set-until-match latch; a set edge in the matching cycle wins.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            latch_q    <= 1'b0;
            set_prev_q <= 1'b0;
        end
        else
        begin
            set_prev_q <= lnk.set_bit;
            if (lnk.mode != cmp_pkg::MODE_SET_UNTIL || !lnk.set_bit)
            begin
                latch_q <= 1'b0;
            end
            else if (!set_prev_q)
            begin
                latch_q <= 1'b1;
            end
            else if (lnk.match)
            begin
                latch_q <= 1'b0;
            end
        end
    end

    always_comb
    begin
        case (lnk.mode)
            cmp_pkg::MODE_UPPER:     fn_d = in_upper;
            cmp_pkg::MODE_LOWER:     fn_d = in_lower;
            cmp_pkg::MODE_WINDOW:    fn_d = lnk.is_out_one && in_win;
            cmp_pkg::MODE_PULSE:     fn_d = (pulse_cnt_q != 16'h0000) ||
                                            hold_q;
            cmp_pkg::MODE_SET_UNTIL: fn_d = latch_q;
            cmp_pkg::MODE_OUTSIDE:   fn_d = lnk.is_out_one && !in_win &&
                                        (lnk.ref_sel == cmp_pkg::REF_MEAS);
            default:                 fn_d = 1'b0;
        endcase
    end

    // Level functions settle one cycle after the reference.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            fn_q <= 1'b0;
        end
        else
        begin
            fn_q <= fn_d;
        end
    end

    assign lnk.fn_level = (lnk.mode == cmp_pkg::MODE_PULSE) ? fn_d : fn_q;

endmodule : cmp_eval

// ### dv/cos_props.sv
// Port checks of the compare output switch.
`timescale 1ns/1ps
module cos_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Reference strobes
    input wire logic        count_pulse,
    input wire logic        pos_update,
    // Outputs
    input wire logic        switch_out_zero,
    input wire logic        switch_out_one,
    input wire logic [1:0]  out_state_flag,
    input wire logic [1:0]  compare_hit_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic req;
    logic clr0;
    assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign clr0 = req && wb_we_i && wb_adr_i == cmp_pkg::OFS_STATUS
                  && wb_sel_i[0] && wb_dat_i[2];
    ack_resp_a: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    state_mirror_a: assert property (
        out_state_flag == {switch_out_one, switch_out_zero})
        else $error("state flag differs from outputs");
    hit_sticky_a: assert property (compare_hit_flag[0] && !clr0
        |=> compare_hit_flag[0]) else $error("hit flag lost");
    hit_cause_a: assert property (
        $rose(compare_hit_flag[0]) |-> $past(count_pulse || pos_update))
        else $error("hit flag without step");
    hit_clear_a: assert property (clr0 && !count_pulse && !pos_update
        |=> !compare_hit_flag[0]) else $error("hit flag not cleared");
    rd_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    cover property ($rose(compare_hit_flag[0]));
    cover property ($rose(switch_out_one));
    cover property (clr0 && compare_hit_flag[0]);
endmodule : cos_props
bind compare_output_switch cos_props u_props (.clk_sys, .nrst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .count_pulse, .pos_update, .switch_out_zero,
    .switch_out_one, .out_state_flag, .compare_hit_flag);

// ### dv/count_src.sv
// Counting logic beside the channel: steps and loads the counter value.
`timescale 1ns/1ps
module count_src (
    // Clock
    input wire logic    clk_sys,
    // Counter
    output logic [31:0] count_value,
    output logic        count_pulse,
    output logic        count_up
);
    initial
    begin
        count_value = 32'h0000_0000;
        count_pulse = 1'b0;
        count_up    = 1'b1;
    end
    // A load moves the value with no step pulse, as a synchronization does.
    task automatic load(input logic [31:0] v);
        @(posedge clk_sys);
        count_value <= v;
    endtask : load
    task automatic step(input logic up);
        @(posedge clk_sys);
        count_value <= up ? count_value + 32'h1 : count_value - 32'h1;
        count_pulse <= 1'b1;
        count_up    <= up;
        @(posedge clk_sys);
        count_pulse <= 1'b0;
    endtask : step
endmodule : count_src

// ### dv/tb.sv
// Self-checking bench of the compare output switch.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
    logic        clk_sys = 1'b0;
    logic        nrst    = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0;
    logic [31:0] meas    = 32'h0;
    logic [31:0] pos     = 32'h0;
    logic        pupd    = 1'b0;
    logic [3:0]  sel     = 4'hF;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic [31:0] cval;
    logic        ack;
    logic        cpul;
    logic        cup;
    logic        o0;
    logic        o1;
    logic [1:0]  st;
    logic [1:0]  hit;
    int          bad_count   = 0;
    int          check_count = 0;
    always #5 clk_sys = ~clk_sys;
    count_src src (.clk_sys(clk_sys), .count_value(cval),
        .count_pulse(cpul), .count_up(cup));
    compare_output_switch dut (.clk_sys(clk_sys), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .count_value(cval), .count_pulse(cpul), .count_up(cup),
        .pos_value(pos), .pos_update(pupd), .meas_value(meas),
        .switch_out_zero(o0), .switch_out_one(o1), .out_state_flag(st),
        .compare_hit_flag(hit));
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 40)
            begin
                bad_count++;
                summarize();
            end
            @(posedge clk_sys);
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cy
    // New position sample with a one-cycle update strobe.
    task automatic pstep(input logic [31:0] v);
        @(posedge clk_sys);
        pos  <= v;
        pupd <= 1'b1;
        @(posedge clk_sys);
        pupd <= 1'b0;
    endtask : pstep
    // Control word: owners, set bits, reference, modes, directions.
    function automatic logic [31:0] ctl(input logic [1:0] own, set,
        input logic [1:0] rf, input logic [2:0] m0, m1, input logic [1:0] dr);
        return 32'(own) | 32'(set) << 2 | 32'(rf) << 4 | 32'(m0) << 8
            | 32'(m1) << 12 | 32'(dr) << 16;
    endfunction : ctl
    logic [7:0]  ra [5] = '{8'h00, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rv [5] = '{cmp_pkg::RST_CTRL, cmp_pkg::RST_POS_MAX,
        cmp_pkg::RST_LOW_LIM, cmp_pkg::RST_HIGH_LIM, 32'h0};
    logic [31:0] cv [4] = '{32'd9, 32'd10, 32'd20, 32'd21};
    logic [1:0]  ea [4] = '{2'h1, 2'h3, 2'h3, 2'h2};
    logic [1:0]  eb [4] = '{2'h0, 2'h1, 2'h1, 2'h1};
    initial
    begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, ra[i], 32'h0);
            `CHK("reset value", rv[i], rdat)
        end
        sel <= 4'h1;
        wb(1'b1, 8'h18, 32'h0000_0055);
        sel <= 4'hF;
        wb(1'b0, 8'h18, 32'h0);
        `CHK("byte lane", 32'h8000_0055, rdat)
        wb(1'b1, 8'h00, ctl(2'h0, 2'h1, 2'h0, 3'h1, 3'h0, 2'h0));
        cy(2);
        `CHK("soft out0", 2'h1, st)
        wb(1'b1, 8'h00, ctl(2'h0, 2'h0, 2'h0, 3'h1, 3'h0, 2'h0));
        cy(2);
        `CHK("soft out0 low", 1'b0, o0)
        wb(1'b1, 8'h04, 32'd10);
        wb(1'b1, 8'h08, 32'd20);
        wb(1'b1, 8'h00, ctl(2'h3, 2'h0, 2'h0, 3'h1, 3'h2, 2'h0));
        for (int i = 0; i < 4; i++)
        begin
            src.load(cv[i]);
            cy(3);
            `CHK("upper lower", ea[i], {o0, o1})
        end
        wb(1'b1, 8'h00, ctl(2'h2, 2'h0, 2'h0, 3'h0, 3'h3, 2'h0));
        for (int i = 0; i < 4; i++)
        begin
            if (i == 3)
                wb(1'b1, 8'h08, 32'd30);
            src.load(cv[i]);
            cy(3);
            `CHK("window", eb[i], {o0, o1})
        end
        wb(1'b1, 8'h04, 32'd30);
        wb(1'b1, 8'h0C, 32'd3);
        wb(1'b1, 8'h00, ctl(2'h1, 2'h0, 2'h0, 3'h4, 3'h0, 2'h1));
        src.load(32'd30);
        cy(3);
        `CHK("no pulse on load", 1'b0, o0)
        src.step(1'b1);
        src.step(1'b0);
        cy(2);
        `CHK("no pulse down", 2'h0, {o0, hit[0]})
        src.load(32'd29);
        src.step(1'b1);
        cy(1);
        `CHK("pulse", 2'h3, {o0, hit[0]})
        cy(3);
        `CHK("pulse end", 1'b0, o0)
        wb(1'b1, 8'h10, 32'h4);
        cy(1);
        `CHK("hit clear", 1'b0, hit[0])
        wb(1'b1, 8'h0C, 32'd0);
        src.load(32'd29);
        src.step(1'b1);
        cy(6);
        `CHK("zero length", 1'b1, o0)
        src.step(1'b1);
        cy(2);
        `CHK("zero length end", 1'b0, o0)
        wb(1'b1, 8'h08, 32'd40);
        src.load(32'd38);
        wb(1'b1, 8'h00, ctl(2'h2, 2'h2, 2'h0, 3'h0, 3'h5, 2'h2));
        cy(3);
        `CHK("set until", 1'b1, o1)
        src.step(1'b1);
        src.step(1'b1);
        cy(2);
        `CHK("set until match", 2'h1, {o1, hit[1]})
        wb(1'b1, 8'h04, 32'd10);
        wb(1'b1, 8'h08, 32'd20);
        wb(1'b1, 8'h00, ctl(2'h2, 2'h0, 2'h2, 3'h0, 3'h6, 2'h0));
        meas <= 32'd15;
        cy(3);
        `CHK("inside", 1'b0, o1)
        @(posedge clk_sys);
        meas <= 32'd25;
        cy(3);
        `CHK("outside", 1'b1, o1)
        wb(1'b1, 8'h00, ctl(2'h3, 2'h0, 2'h2, 3'h1, 3'h2, 2'h0));
        meas <= 32'd10;
        cy(3);
        `CHK("above below", 2'h3, {o0, o1})
        wb(1'b1, 8'h00, ctl(2'h3, 2'h0, 2'h1, 3'h1, 3'h2, 2'h0));
        pstep(32'h0001_0000);
        cy(3);
        `CHK("pos above max", 2'h0, {o0, o1})
        pstep(32'd15);
        cy(3);
        `CHK("pos ranges", 2'h3, {o0, o1})
        wb(1'b1, 8'h00, ctl(2'h1, 2'h0, 2'h1, 3'h4, 3'h0, 2'h1));
        pstep(32'd5);
        pstep(32'd12);
        cy(1);
        `CHK("pos crossing", 1'b1, o0)
        summarize();
    end
endmodule : tb
